// [logic/uvc_interp.sv]
// command slice: variable-immediate calc, restart, decrement loop
// assumes byte streams with valid/ready, one clock, program fetch elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "uvc_defs.svh"
module uvc_interp import uvc_pkg::*; #(
	parameter int PC_W = 16,
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// host command bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_ready,
	// reply bytes
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	// stored-program side: instruction issued by fetch
	input wire logic prog_valid,
	input wire logic [7:0] prog_op,
	input wire logic [7:0] prog_type,
	input wire logic [7:0] prog_bank,
	input wire logic [31:0] prog_value,
	output logic prog_ready,
	// interpreter state
	input wire logic pc_advance,
	output logic [PC_W-1:0] pc,
	output logic [31:0] accu,
	output logic [31:0] xreg,
	output logic [3:0] sub_depth,
	output logic [3:0] irq_depth,
	output logic flag_zero,
	output logic flag_equal,
	output logic flag_greater,
	output logic flag_lower,
	output logic restart_pulse
);
	uvc_frame_if fr ();
	uvc_csum u_csum (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .fr(fr.acc));

	uvc_state_t state_reg;
	logic [3:0] idx_reg;
	logic [7:0] frame_reg [0:8];
	logic [31:0] uvar [0:255];
	logic direct_reg;
	logic [7:0] op_reg, type_reg, bank_reg, status_reg;
	logic [31:0] val_reg, var_reg, res_reg;
	logic wr_reg;
	logic [PC_W-1:0] pc_reg;
	logic [31:0] accu_reg, xreg_reg;
	logic [3:0] sub_reg, irq_reg;
	uvc_flags_t flags_reg;
	logic restart_reg;
	logic [7:0] var_idx;
	logic [7:0] reply_byte;

	// calc selects by bank, loop selects by type
	assign var_idx = (op_reg == `UVC_OP_LOOP) ? type_reg : bank_reg; // [RL1] [RL12]

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= UVC_IDLE;
			idx_reg <= 4'h0;
			direct_reg <= 1'b0;
		end else if (clk_en) begin
			case (state_reg)
				UVC_IDLE: begin
					idx_reg <= 4'h0;
					if (rx_valid) begin
						state_reg <= UVC_RX;
						direct_reg <= 1'b1;
					end else if (prog_valid) begin
						state_reg <= UVC_EXEC;
						direct_reg <= 1'b0;
					end
				end
				UVC_RX: begin
					if (rx_valid) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == `UVC_LAST_IDX)
							state_reg <= UVC_EXEC; // [RL14]
					end
				end
				UVC_EXEC: state_reg <= UVC_WB;
				UVC_WB: begin
					idx_reg <= 4'h0;
					state_reg <= direct_reg ? UVC_TX : UVC_IDLE;
				end
				UVC_TX: begin
					// ready alone must not move the index, or a byte is skipped
					if (tx_valid && tx_ready) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == `UVC_LAST_IDX)
							state_reg <= UVC_IDLE;
					end
				end
				default: state_reg <= UVC_IDLE;
			endcase
		end
	end

	// command bytes kept whole; value reassembled msb first
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < `UVC_FRAME_LEN; i++)
				frame_reg[i] <= 8'h00;
		end else if (clk_en && state_reg == UVC_RX && rx_valid) begin
			frame_reg[idx_reg] <= rx_data;
		end
	end

	// latch decoded fields at start of execute
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			op_reg <= 8'h00;
			type_reg <= 8'h00;
			bank_reg <= 8'h00;
			val_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (state_reg == UVC_IDLE && !rx_valid && prog_valid) begin
				op_reg <= prog_op;
				type_reg <= prog_type;
				bank_reg <= prog_bank;
				val_reg <= prog_value;
			end else if (state_reg == UVC_RX && rx_valid && idx_reg == `UVC_LAST_IDX) begin
				op_reg <= frame_reg[1];
				type_reg <= frame_reg[2];
				bank_reg <= frame_reg[3];
				val_reg <= {frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]}; // [RL15]
			end
		end
	end

	// checksum of received and reply bytes, received sum checked when the ninth byte arrives
	always_comb begin
		fr.clear = 1'b0;
		fr.add = 1'b0;
		fr.data = 8'h00;
		if (state_reg == UVC_IDLE) begin
			fr.clear = 1'b1;
		end else if (state_reg == UVC_RX && rx_valid && idx_reg != `UVC_LAST_IDX) begin
			fr.add = 1'b1;
			fr.data = rx_data;
		end else if (state_reg == UVC_WB) begin
			fr.clear = 1'b1;
		end else if (state_reg == UVC_TX && tx_valid && tx_ready && idx_reg != `UVC_LAST_IDX) begin
			// only bytes really handed over enter the sum
			fr.add = 1'b1;
			fr.data = reply_byte;
		end
	end

	// status: checksum is judged before the command executes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg <= `UVC_ST_OK;
		end else if (clk_en) begin
			if (state_reg == UVC_IDLE) begin
				status_reg <= `UVC_ST_OK;
			end else if (state_reg == UVC_RX && rx_valid && idx_reg == `UVC_LAST_IDX) begin
				if (rx_data != fr.sum)
					status_reg <= `UVC_ST_BAD_CSUM; // [RL16]
			end else if (state_reg == UVC_EXEC && status_reg == `UVC_ST_OK) begin
				if (op_reg != `UVC_OP_CALC && op_reg != `UVC_OP_RESTART && op_reg != `UVC_OP_LOOP)
					status_reg <= `UVC_ST_BAD_CMD;
				else if (op_reg == `UVC_OP_CALC && type_reg > `UVC_T_LOAD && type_reg != `UVC_T_COMP)
					status_reg <= `UVC_ST_BAD_TYPE; // [RL5]
			end
		end
	end

	// variable read; divide by zero leaves the variable unchanged
	// indexed by the incoming fields: the latched ones are still stale on this edge
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			var_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (state_reg == UVC_IDLE && !rx_valid && prog_valid)
				var_reg <= uvar[(prog_op == `UVC_OP_LOOP) ? prog_type : prog_bank]; // [RL1] [RL12]
			else if (state_reg == UVC_RX && rx_valid && idx_reg == `UVC_LAST_IDX)
				var_reg <= uvar[(frame_reg[1] == `UVC_OP_LOOP) ? frame_reg[2] : frame_reg[3]]; // [RL1] [RL12]
		end
	end

	always_comb begin
		res_reg = var_reg;
		wr_reg = 1'b0;
		if (op_reg == `UVC_OP_CALC) begin
			wr_reg = 1'b1; // [RL1]
			case (type_reg)
				`UVC_T_ADD: res_reg = var_reg + val_reg; // [RL2]
				`UVC_T_SUB: res_reg = var_reg - val_reg; // [RL2]
				`UVC_T_MUL: res_reg = var_reg * val_reg; // [RL2]
				`UVC_T_DIV: res_reg = (val_reg == 32'h0) ? var_reg : 32'($signed(var_reg) / $signed(val_reg)); // [RL2]
				`UVC_T_MOD: res_reg = (val_reg == 32'h0) ? var_reg : 32'($signed(var_reg) % $signed(val_reg)); // [RL2]
				`UVC_T_AND: res_reg = var_reg & val_reg; // [RL2]
				`UVC_T_OR: res_reg = var_reg | val_reg; // [RL2]
				`UVC_T_XOR: res_reg = var_reg ^ val_reg; // [RL2]
				`UVC_T_NOT: res_reg = ~var_reg; // [RL3]
				`UVC_T_LOAD: res_reg = val_reg; // [RL4]
				default: wr_reg = 1'b0;
			endcase
		end else if (op_reg == `UVC_OP_LOOP) begin
			wr_reg = 1'b1;
			res_reg = var_reg - 32'h0000_0001; // [RL13]
		end
	end

	// user variable store, no reset: a memory, not control state
	always_ff @(posedge clk_sys) begin
		if (clk_en && state_reg == UVC_EXEC && status_reg == `UVC_ST_OK && wr_reg)
			uvar[var_idx] <= res_reg; // [RL2]
	end

	// program counter, stacks, registers
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pc_reg <= '0;
			accu_reg <= 32'h0000_0000;
			xreg_reg <= 32'h0000_0000;
			sub_reg <= 4'h0;
			irq_reg <= 4'h0;
			restart_reg <= 1'b0;
		end else if (clk_en) begin
			restart_reg <= 1'b0;
			if (state_reg == UVC_EXEC && status_reg == `UVC_ST_OK && op_reg == `UVC_OP_RESTART) begin
				// unconditional, so nesting depth never blocks it
				sub_reg <= 4'h0; // [RL9] [RL10]
				irq_reg <= 4'h0; // [RL9] [RL10]
				accu_reg <= 32'h0000_0000; // [RL9]
				xreg_reg <= 32'h0000_0000; // [RL9]
				pc_reg <= val_reg[PC_W-1:0]; // [RL8]
				restart_reg <= 1'b1; // [RL8]
			end else if (state_reg == UVC_EXEC && status_reg == `UVC_ST_OK && op_reg == `UVC_OP_LOOP
				&& res_reg != 32'h0000_0000) begin
				pc_reg <= val_reg[PC_W-1:0]; // [RL13]
			end else if (pc_advance) begin
				pc_reg <= pc_reg + 1'b1;
			end
		end
	end

	// comparison flags, signed
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flags_reg <= '0;
		end else if (clk_en && state_reg == UVC_EXEC && status_reg == `UVC_ST_OK) begin
			if (op_reg == `UVC_OP_RESTART) begin
				flags_reg <= '0; // [RL9]
			end else if (op_reg == `UVC_OP_CALC && type_reg == `UVC_T_COMP) begin
				flags_reg.zero <= (var_reg == val_reg); // [RL5]
				flags_reg.equal <= (var_reg == val_reg); // [RL5]
				flags_reg.greater <= ($signed(var_reg) > $signed(val_reg)); // [RL5]
				flags_reg.lower <= ($signed(var_reg) < $signed(val_reg)); // [RL5]
			end
		end
	end

	// reply: host, module, status, echo, value msb first, checksum
	always_comb begin
		case (idx_reg)
			4'h0: reply_byte = `UVC_HOST_ADDR; // [RL14]
			4'h1: reply_byte = `UVC_MOD_ADDR;
			4'h2: reply_byte = status_reg; // [RL6]
			4'h3: reply_byte = op_reg;
			4'h4: reply_byte = val_reg[31:24]; // [RL15]
			4'h5: reply_byte = val_reg[23:16];
			4'h6: reply_byte = val_reg[15:8];
			4'h7: reply_byte = val_reg[7:0]; // [RL6]
			default: reply_byte = fr.sum; // [RL16]
		endcase
	end

	// tx byte held in a flop, refreshed as the index moves
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_data <= 8'h00;
		end else if (clk_en) begin
			tx_data <= reply_byte;
		end
	end

	assign rx_ready = (state_reg == UVC_RX);
	assign prog_ready = (state_reg == UVC_IDLE) && !rx_valid;
	// valid waits until the flop holds the byte the index points at
	// costs one idle cycle per byte, but keeps tx_data a flop
	assign tx_valid = (state_reg == UVC_TX) && (tx_data == reply_byte);
	assign pc = pc_reg;
	assign accu = accu_reg;
	assign xreg = xreg_reg;
	assign sub_depth = sub_reg;
	assign irq_depth = irq_reg;
	assign flag_zero = flags_reg.zero;
	assign flag_equal = flags_reg.equal;
	assign flag_greater = flags_reg.greater;
	assign flag_lower = flags_reg.lower;
	assign restart_pulse = restart_reg;
endmodule : uvc_interp
`default_nettype wire

// [logic/uvc_defs.svh]
// constants for the user variable calc / restart / loop interpreter slice
// assumes inclusion by bare name from design files
// Contract
// RL1: opcode 45 modifies indexed user variable
// RL2: types 0-7 arithmetic/logic, result written back
// RL3: type 8 inverts variable, value ignored
// RL4: type 9 loads value into variable
// RL5: type 11 compares, sets flags; no swap
// RL6: direct-mode reply status 100, value echoed
// RL7: host uses calc mainly in programs
// RL8: opcode 48 restarts at value address
// RL9: restart clears stacks and registers
// RL10: restart works at any nesting depth
// RL11: host avoids restart/loop in direct mode
// RL12: opcode 49 index in type, target value
// RL13: decrement; nonzero loads pc, else next
// RL14: nine byte command and reply frames
// RL15: value field most significant byte first
// RL16: checksum is byte sum modulo 256
`ifndef UVC_DEFS_SVH
`define UVC_DEFS_SVH
`define UVC_OP_CALC 8'h2d
`define UVC_OP_RESTART 8'h30
`define UVC_OP_LOOP 8'h31
`define UVC_T_ADD 8'h00
`define UVC_T_SUB 8'h01
`define UVC_T_MUL 8'h02
`define UVC_T_DIV 8'h03
`define UVC_T_MOD 8'h04
`define UVC_T_AND 8'h05
`define UVC_T_OR 8'h06
`define UVC_T_XOR 8'h07
`define UVC_T_NOT 8'h08
`define UVC_T_LOAD 8'h09
`define UVC_T_COMP 8'h0b
`define UVC_ST_OK 8'h64
`define UVC_ST_BAD_CSUM 8'h01
`define UVC_ST_BAD_CMD 8'h02
`define UVC_ST_BAD_TYPE 8'h03
`define UVC_FRAME_LEN 4'h9
`define UVC_LAST_IDX 4'h8
`define UVC_HOST_ADDR 8'h02
`define UVC_MOD_ADDR 8'h01
`endif

// [logic/uvc_pkg.sv]
// types for the user variable calc / restart / loop slice
// assumes uvc_defs.svh is present
package uvc_pkg;
	typedef enum logic [4:0] {
		UVC_IDLE = 5'h01,
		UVC_RX = 5'h02,
		UVC_EXEC = 5'h04,
		UVC_WB = 5'h08,
		UVC_TX = 5'h10
	} uvc_state_t;
	typedef struct packed {
		logic zero;
		logic equal;
		logic greater;
		logic lower;
	} uvc_flags_t;
endpackage : uvc_pkg

// [logic/uvc_frame_if.sv]
// byte stream carrier with running checksum between frame modules
// assumes single clock domain
`timescale 1ns/1ps
`default_nettype none
interface uvc_frame_if;
	logic clear;
	logic add;
	logic [7:0] data;
	logic [7:0] sum;
	modport owner (output clear, output add, output data, input sum);
	modport acc (input clear, input add, input data, output sum);
endinterface : uvc_frame_if
`default_nettype wire

// [logic/uvc_csum.sv]
// running modulo-256 byte sum for frame checksums
// assumes synchronous clear and add strobes
`timescale 1ns/1ps
`default_nettype none
`include "uvc_defs.svh"
module uvc_csum (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// stream
	uvc_frame_if.acc fr
);
	logic [7:0] sum_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sum_reg <= 8'h00;
		end else if (clk_en) begin
			if (fr.clear)
				sum_reg <= fr.add ? fr.data : 8'h00;
			else if (fr.add)
				sum_reg <= sum_reg + fr.data; // [RL16]
		end
	end
	assign fr.sum = sum_reg;
endmodule : uvc_csum
`default_nettype wire

// [dv/uvc_interp_assertions.sv]
// port checks for the calc / restart / loop slice
// assumes bind onto uvc_interp, one clock domain
`timescale 1ns/1ps
`default_nettype none
module uvc_interp_assertions (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// streams
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic prog_ready,
	// state
	input wire logic [31:0] accu,
	input wire logic [31:0] xreg,
	input wire logic [3:0] sub_depth,
	input wire logic [3:0] irq_depth,
	input wire logic flag_zero,
	input wire logic flag_equal,
	input wire logic flag_greater,
	input wire logic flag_lower,
	input wire logic restart_pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	tx_hold_a: assert property (tx_valid && !tx_ready && clk_en |=> tx_valid && $stable(tx_data))
		else $error("reply byte changed before acceptance");
	rx_tx_excl_a: assert property (!(rx_ready && tx_valid))
		else $error("receive and reply overlap");
	direct_prio_a: assert property (rx_valid |-> !prog_ready)
		else $error("program taken during a host frame");
	pulse_once_a: assert property (restart_pulse && clk_en |=> !restart_pulse)
		else $error("restart pulse longer than one cycle");
	restart_clear_a: assert property (restart_pulse |-> accu == 32'h0 && xreg == 32'h0)
		else $error("registers survive restart");
	depth_zero_a: assert property (sub_depth == 4'h0 && irq_depth == 4'h0)
		else $error("stack depth not zero");
	zero_equal_a: assert property (flag_zero == flag_equal)
		else $error("zero and equal flags differ");
	flags_excl_a: assert property ($onehot0({flag_equal, flag_greater, flag_lower}))
		else $error("compare flags not exclusive");
endmodule : uvc_interp_assertions
`default_nettype wire

// [dv/uvc_host.sv]
// host model: sends command frames, collects replies
// assumes falling-edge drive, tasks called from the bench
`timescale 1ns/1ps
`default_nettype none
module uvc_host (
	// clock
	input wire logic clk_sys,
	// command bytes
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	// reply bytes
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic tick = 1'b0;
	logic [7:0] reply [9];
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	task automatic frame(input logic [7:0] op, ty, bk, input logic [31:0] v, input logic [7:0] bad);
		logic [7:0] b [9];
		b = '{8'h01, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		for (int i = 0; i < 8; i++) b[8] += b[i];
		b[8] ^= bad;
		for (int i = 0; i < 9; i++) begin
			@(negedge clk_sys);
			rx_valid = 1'b1;
			rx_data = b[i];
			do @(posedge clk_sys); while (rx_ready !== 1'b1);
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		// released line shows the inverse, not a stale byte
		rx_data = ~rx_data;
		for (int i = 0; i < 9; i++) begin
			do begin
				@(negedge clk_sys);
				tick = !tick;
				tx_ready = !slow || tick;
				@(posedge clk_sys);
			end while (!(tx_valid === 1'b1 && tx_ready));
			reply[i] = tx_data;
		end
		@(negedge clk_sys);
		tx_ready = 1'b0;
	endtask : frame
endmodule : uvc_host
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench for uvc_interp with a host model
// assumes uvc_host partner and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic rx_valid, rx_ready, tx_valid, tx_ready, prog_ready, restart_pulse;
	logic flag_zero, flag_equal, flag_greater, flag_lower;
	logic prog_valid = 1'b0;
	logic pc_advance = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] rx_data, tx_data, idx;
	logic [7:0] prog_op = 8'h00, prog_type = 8'h00, prog_bank = 8'h00;
	logic [31:0] prog_value = 32'h0, accu, xreg, x, y;
	logic [31:0] mv [256];
	logic [15:0] pc;
	logic [3:0] sub_depth, irq_depth;
	logic [7:0] ops [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0a, 8'h0c};
	int fail_count = 0, comparisons = 0, pulses = 0, e = 0, seed = 32'h6ac77fff;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (restart_pulse === 1'b1) pulses++;
	uvc_interp i_uvc_interp (.clk_sys, .sys_rst, .clk_en, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
		.tx_ready, .prog_valid, .prog_op, .prog_type, .prog_bank, .prog_value, .prog_ready, .pc_advance, .pc, .accu,
		.xreg, .sub_depth, .irq_depth, .flag_zero, .flag_equal, .flag_greater, .flag_lower, .restart_pulse);
	uvc_host i_uvc_host (.clk_sys, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);
	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] calc(input logic [7:0] ty, input logic [31:0] a, b);
		case (ty)
			8'h00: return a + b;
			8'h01: return a - b;
			8'h02: return a * b;
			// operands kept positive, so signed and unsigned division agree
			8'h03: return (b == 0) ? a : a / b;
			8'h04: return (b == 0) ? a : a % b;
			8'h05: return a & b;
			8'h06: return a | b;
			8'h07: return a ^ b;
			8'h08: return ~a;
			8'h09: return b;
			default: return a;
		endcase
	endfunction : calc
	task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v, input logic [7:0] bad, st);
		logic [7:0] r [9];
		r = '{8'h02, 8'h01, st, op, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		for (int i = 0; i < 8; i++) r[8] += r[i];
		i_uvc_host.frame(op, ty, bk, v, bad);
		for (int i = 0; i < 9; i++) check("reply", i_uvc_host.reply[i], r[i]);
	endtask : cmd
	task automatic var_immediate_calc(input logic [7:0] ty, k, input logic [31:0] v);
		cmd(8'h2d, ty, k, v, 8'h00, (ty == 8'h0a || ty > 8'h0b) ? 8'h03 : 8'h64);
		mv[k] = calc(ty, mv[k], v);
	endtask : var_immediate_calc
	task automatic comp(input logic [7:0] k, input logic [31:0] v);
		cmd(8'h2d, 8'h0b, k, v, 8'h00, 8'h64);
		check("equal", flag_equal, mv[k] == v);
		check("greater", flag_greater, $signed(mv[k]) > $signed(v));
		check("lower", flag_lower, $signed(mv[k]) < $signed(v));
	endtask : comp
	task automatic prog(input logic [7:0] op, ty, input logic [31:0] v);
		@(negedge clk_sys);
		{prog_valid, prog_op, prog_type, prog_value} = {1'b1, op, ty, v};
		prog_bank = 8'($random(seed));
		do @(posedge clk_sys); while (prog_ready !== 1'b1);
		@(negedge clk_sys);
		prog_valid = 1'b0;
		prog_value = ~prog_value;
		repeat (4) @(negedge clk_sys);
	endtask : prog
	task automatic give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#(100 * 40000);
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (16) @(negedge clk_sys);
		sys_rst = 1'b0;
		for (int p = 0; p < 2; p++) foreach (ops[j]) begin
			idx = 8'($random(seed));
			x = $random(seed) & 32'h0000ffff;
			y = p ? 32'h0 : $random(seed) & 32'h0000ffff;
			i_uvc_host.slow = j[0];
			var_immediate_calc(8'h09, idx, x);
			if (ops[j] == 8'h0b) comp(idx, y);
			else var_immediate_calc(ops[j], idx, y);
			comp(idx, mv[idx]);
		end
		cmd(8'h2d, 8'h09, idx, 32'h1, 8'h01, 8'h01);
		cmd(8'h07, 8'h00, idx, 32'h1, 8'h00, 8'h02);
		comp(idx, mv[idx]);
		var_immediate_calc(8'h09, 8'hff, 32'h2);
		prog(8'h31, 8'hff, 32'h0123);
		check("pc", pc, 32'h0123);
		prog(8'h31, 8'hff, 32'h0456);
		check("pc hold", pc, 32'h0123);
		mv[255] = 32'h0;
		comp(8'hff, 32'h0);
		e = pulses;
		prog(8'h30, 8'($random(seed)), 32'h000a);
		check("pc", pc, 32'h000a);
		check("pulses", pulses, e + 1);
		check("accu", accu, 32'h0);
		check("xreg", xreg, 32'h0);
		check("flags", {flag_zero, flag_equal, flag_greater, flag_lower}, 32'h0);
		pc_advance = 1'b1;
		@(negedge clk_sys);
		check("pc step", pc, 32'h000b);
		clk_en = 1'b0;
		@(negedge clk_sys);
		check("pc frozen", pc, 32'h000b);
		clk_en = 1'b1;
		@(negedge clk_sys);
		pc_advance = 1'b0;
		check("pc step", pc, 32'h000c);
		give_verdict;
	end
endmodule : testbench
bind uvc_interp uvc_interp_assertions i_uvc_interp_assertions (.clk_sys, .sys_rst, .clk_en, .rx_valid, .rx_ready,
	.tx_valid, .tx_data, .tx_ready, .prog_ready, .accu, .xreg, .sub_depth, .irq_depth, .flag_zero, .flag_equal,
	.flag_greater, .flag_lower, .restart_pulse);
`default_nettype wire
